// file: design/sppm_pkg.sv
// Register map, field positions and reset values of the port power block
package sppm_pkg;
   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] SPPM_CAP_ADDR    = 8'hC0;
   localparam logic [7:0] SPPM_CSR_ADDR    = 8'hC4;
   localparam logic [7:0] SPPM_IRQ_ST_ADDR = 8'hC8;
   localparam logic [7:0] SPPM_IRQ_MK_ADDR = 8'hCC;
   // ---------------------------------------------------------------
   // Capability word fields
   // ---------------------------------------------------------------
   localparam logic [7:0] SPPM_CAP_ID      = 8'h01;
   localparam int         SPPM_CAPID_LSB   = 0;
   localparam int         SPPM_NEXT_LSB    = 8;
   localparam logic [7:0] SPPM_NEXT_UP     = 8'h00;
   localparam logic [7:0] SPPM_NEXT_DOWN   = 8'hD0;
   localparam int         SPPM_VER_LSB     = 16;
   localparam logic [2:0] SPPM_VER         = 3'h3;
   localparam int         SPPM_DEVINIT_BIT = 21;
   localparam logic       SPPM_DEVINIT_RST = 1'b0;
   localparam int         SPPM_WMASK_LSB   = 27;
   localparam logic [4:0] SPPM_WMASK_RST   = 5'h19;
   // ---------------------------------------------------------------
   // Control and status word fields
   // ---------------------------------------------------------------
   localparam int         SPPM_POWER_STATE_FIELD_LSB  = 0;
   localparam int         SPPM_KEEP_BIT    = 3;
   localparam logic       SPPM_KEEP_RST    = 1'b1;
   localparam int         SPPM_WEN_BIT     = 8;
   localparam int         SPPM_WST_BIT     = 15;
   // Interrupt status and mask bits
   localparam int         SPPM_IRQ_WAKE    = 0;
   localparam int         SPPM_IRQ_PSCHG   = 1;
   localparam int         SPPM_IRQ_N       = 2;
   // ---------------------------------------------------------------
   // Power states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SPPM_D0    = 2'h0,
      SPPM_D1    = 2'h1,
      SPPM_D2    = 2'h2,
      SPPM_D3HOT = 2'h3
   } sppm_power_state_field_t;
   // Wake-mask bit index of D0, D3hot and D3cold; bit 27 is D0, 31 is D3cold
   localparam int         SPPM_WM_D0       = 0;
   localparam int         SPPM_WM_D3HOT    = 3;
   localparam int         SPPM_WM_D3COLD   = 4;
endpackage

// file: design/sppm_wake_gen.sv
// Wake message gating and event qualification for one port
`timescale 1ns/1ps
`default_nettype none
module sppm_wake_gen
  import sppm_pkg::*;
(
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // State
   input  wire sppm_pkg::sppm_power_state_field_t power_state_field,
   input  wire logic         cold_d3,
   input  wire logic         wake_enable,
   input  wire logic         is_upstream,
   // Wake sources
   input  wire logic         own_wake,
   input  wire logic         fwd_wake,
   // Results
   output logic              own_event,
   output logic              wake_msg_out
);
   import sppm_pkg::*;

   // ---------------------------------------------------------------
   // Allowed states
   // ---------------------------------------------------------------
   // Fixed mask: software edits to the advertised mask do not reach here
   logic [4:0] allow_mask;
   logic       state_ok;
   assign allow_mask = SPPM_WMASK_RST;
   always_comb begin
      if (cold_d3) begin
         state_ok = allow_mask[SPPM_WM_D3COLD];
      end else if (power_state_field == SPPM_D3HOT) begin
         state_ok = allow_mask[SPPM_WM_D3HOT];
      end else begin
         state_ok = allow_mask[SPPM_WM_D0];
      end
   end

   // Upstream port never originates a wake event
   assign own_event = own_wake && !is_upstream && !cold_d3;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_msg_out <= 1'b0;
      end else begin
         wake_msg_out <= state_ok && !cold_d3 &&
                         ((own_event && wake_enable) || fwd_wake);
      end
   end

   chk_cold_silent: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(cold_d3) |-> !wake_msg_out)
      else $error("wake message sent in cold D3");
endmodule
`default_nettype wire

// file: design/sppm_regs.sv
// Port power management register bank with APB slave and wake interrupt
// How it works
// - The capability word shows identifier 1 in bits 7:0.
// - Bit 21 resets to zero and is writable only while the lock is open.
// - Bits 24:22 of the capability word always read zero.
// - Bits 25 and 26 read zero since neither intermediate state exists.
// - The wake mask in bits 31:27 resets to 11001 binary.
// - Writing the wake mask changes only the value read back.
// - No wake message leaves the port while in cold D3.
// - Bits 1:0 hold the power state, reset to D0, 3 meaning D3hot.
// - Bit 3 resets to one, context kept across D3hot to D0.
// - Bit 8 is a sticky enable, reset zero, gating own wake messages.
// - Hot reset leaves bit 8 unchanged.
// - Bit 15 is set by every own wake event and cleared by writing one.
// - Bit 15 stays clear for forwarded wakes and in the upstream port.
// - Bits 14:9 and 31:24 of the control word read zero.
// - Bits 22 and 23 of the control word read zero.
`timescale 1ns/1ps
`default_nettype none
module sppm_regs
  import sppm_pkg::*;
#(
   parameter logic IS_UPSTREAM = 1'b0
)(
   // Clock and resets
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        sticky_rstn,
   input  wire logic        hot_reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Port controls
   input  wire logic        cfg_unlock,
   input  wire logic        cold_d3,
   // Wake sources
   input  wire logic        own_wake,
   input  wire logic        fwd_wake,
   // Outputs
   output logic             wake_msg_out,
   output logic [1:0]       power_state,
   output logic             context_keep,
   output logic             irq
);
   import sppm_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic       cold_s;
   logic       own_s;
   logic       fwd_s;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {cold_d3, own_wake, fwd_wake};
         sync_b <= sync_a;
      end
   end
   assign cold_s = sync_b[2];
   assign own_s  = sync_b[1];
   assign fwd_s  = sync_b[0];

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic acc;
   logic wr;
   logic hit_cap;
   logic hit_csr;
   logic hit_ist;
   logic hit_imk;
   logic hit_any;
   assign acc     = psel && penable;
   assign hit_cap = paddr == SPPM_CAP_ADDR;
   assign hit_csr = paddr == SPPM_CSR_ADDR;
   assign hit_ist = paddr == SPPM_IRQ_ST_ADDR;
   assign hit_imk = paddr == SPPM_IRQ_MK_ADDR;
   assign hit_any = hit_cap || hit_csr || hit_ist || hit_imk;
   assign wr      = acc && pwrite && hit_any;
   // Zero wait states keeps the slave simple
   assign pready  = 1'b1;
   assign pslverr = acc && !hit_any;

   // ---------------------------------------------------------------
   // Capability register
   // ---------------------------------------------------------------
   logic       devinit;
   logic [4:0] wmask_adv;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         devinit   <= SPPM_DEVINIT_RST;
         wmask_adv <= SPPM_WMASK_RST;
      end else if (wr && hit_cap && cfg_unlock) begin
         if (pstrb[2]) begin
            devinit <= pwdata[SPPM_DEVINIT_BIT];
         end
         if (pstrb[3]) begin
            wmask_adv <= pwdata[SPPM_WMASK_LSB +: 5];
         end
      end
   end

   // ---------------------------------------------------------------
   // Power state and context flag
   // ---------------------------------------------------------------
   sppm_power_state_field_t power_state_field;
   sppm_power_state_field_t next_power_state_field;
   logic         keep;
   assign next_power_state_field = sppm_power_state_field_t'(pwdata[SPPM_POWER_STATE_FIELD_LSB +: 2]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_state_field <= SPPM_D0;
      end else if (hot_reset) begin
         power_state_field <= SPPM_D0;
      end else if (wr && hit_csr && pstrb[0]) begin
         case (next_power_state_field)
            SPPM_D0:    power_state_field <= SPPM_D0;
            SPPM_D3HOT: power_state_field <= SPPM_D3HOT;
            default:    power_state_field <= power_state_field;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         keep <= SPPM_KEEP_RST;
      end else if (wr && hit_csr && pstrb[0] && cfg_unlock) begin
         keep <= pwdata[SPPM_KEEP_BIT];
      end
   end
   assign power_state  = power_state_field;
   assign context_keep = keep;

   // ---------------------------------------------------------------
   // Sticky wake enable and status
   // ---------------------------------------------------------------
   // Sticky bits reset only on the sticky reset, never on hot reset
   logic wen;
   logic wst;
   logic own_evt;
   always_ff @(posedge pclk or negedge sticky_rstn) begin
      if (!sticky_rstn) begin
         wen <= 1'b0;
      end else if (wr && hit_csr && pstrb[1]) begin
         wen <= pwdata[SPPM_WEN_BIT];
      end
   end
   always_ff @(posedge pclk or negedge sticky_rstn) begin
      if (!sticky_rstn) begin
         wst <= 1'b0;
      end else if (own_evt) begin
         wst <= 1'b1;
      end else if (wr && hit_csr && pstrb[1] && pwdata[SPPM_WST_BIT]) begin
         wst <= 1'b0;
      end
   end

   sppm_wake_gen u_wake (
      .pclk         (pclk),
      .presetn      (presetn),
      .power_state_field       (power_state_field),
      .cold_d3      (cold_s),
      .wake_enable  (wen),
      .is_upstream  (IS_UPSTREAM),
      .own_wake     (own_s),
      .fwd_wake     (fwd_s),
      .own_event    (own_evt),
      .wake_msg_out (wake_msg_out)
   );

   // ---------------------------------------------------------------
   // Interrupt status and mask
   // ---------------------------------------------------------------
   logic [SPPM_IRQ_N-1:0] ist;
   logic [SPPM_IRQ_N-1:0] imk;
   logic [SPPM_IRQ_N-1:0] ev;
   assign ev[SPPM_IRQ_WAKE]  = own_evt;
   assign ev[SPPM_IRQ_PSCHG] = wr && hit_csr && pstrb[0] &&
                               (next_power_state_field == SPPM_D0 ||
                                next_power_state_field == SPPM_D3HOT) &&
                               next_power_state_field != power_state_field;
   genvar gi;
   generate
      for (gi = 0; gi < SPPM_IRQ_N; gi++) begin : g_irq
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ist[gi] <= 1'b0;
            end else if (ev[gi]) begin
               ist[gi] <= 1'b1;
            end else if (wr && hit_ist && pstrb[0] && pwdata[gi]) begin
               ist[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imk <= '0;
      end else if (wr && hit_imk && pstrb[0]) begin
         imk <= pwdata[SPPM_IRQ_N-1:0];
      end
   end
   assign irq = |(ist & imk);

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   logic [31:0] cap_word;
   logic [31:0] csr_word;
   logic [7:0]  next_ptr;
   assign next_ptr = IS_UPSTREAM ? SPPM_NEXT_UP : SPPM_NEXT_DOWN;
   always_comb begin
      cap_word = 32'h0;
      cap_word[SPPM_CAPID_LSB +: 8] = SPPM_CAP_ID;
      cap_word[SPPM_NEXT_LSB +: 8] = next_ptr;
      cap_word[SPPM_VER_LSB +: 3] = SPPM_VER;
      cap_word[SPPM_DEVINIT_BIT] = devinit;
      cap_word[SPPM_WMASK_LSB +: 5] = wmask_adv;
   end
   always_comb begin
      csr_word = 32'h0;
      csr_word[SPPM_POWER_STATE_FIELD_LSB +: 2] = power_state_field;
      csr_word[SPPM_KEEP_BIT] = keep;
      csr_word[SPPM_WEN_BIT] = wen;
      csr_word[SPPM_WST_BIT] = wst;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (1'b1)
            hit_cap: prdata <= cap_word;
            hit_csr: prdata <= csr_word;
            hit_ist: prdata <= {{(32-SPPM_IRQ_N){1'b0}}, ist};
            hit_imk: prdata <= {{(32-SPPM_IRQ_N){1'b0}}, imk};
            default: prdata <= 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_capid_const: assert property (@(posedge pclk)
      disable iff (!presetn)
      cap_word[7:0] == SPPM_CAP_ID && cap_word[26:22] == 5'h0)
      else $error("capability id or zero bits wrong");
   chk_rsvd_state: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_csr && pstrb[0] && !hot_reset &&
       (next_power_state_field == SPPM_D1 || next_power_state_field == SPPM_D2))
      |=> $stable(power_state_field))
      else $error("reserved power state accepted");
   chk_state_legal: assert property (@(posedge pclk)
      disable iff (!presetn)
      power_state_field == SPPM_D0 || power_state_field == SPPM_D3HOT)
      else $error("illegal power state held");
   chk_hot_keep: assert property (@(posedge pclk)
      disable iff (!presetn || !sticky_rstn)
      (hot_reset && !(wr && hit_csr && pstrb[1])) |=> $stable(wen))
      else $error("hot reset changed wake enable");
   chk_status_set: assert property (@(posedge pclk)
      disable iff (!presetn || !sticky_rstn)
      own_evt |=> wst)
      else $error("wake status not set by own event");
   chk_status_fwd: assert property (@(posedge pclk)
      disable iff (!presetn || !sticky_rstn)
      (!own_evt && !$past(wst) && !$past(own_evt)) |-> !wst)
      else $error("wake status set without own event");
   chk_up_never: assert property (@(posedge pclk)
      disable iff (!presetn || !sticky_rstn)
      IS_UPSTREAM |-> !own_evt)
      else $error("upstream port raised own wake");
   chk_csr_zero: assert property (@(posedge pclk)
      disable iff (!presetn)
      csr_word[31:16] == 16'h0 && csr_word[14:9] == 6'h0)
      else $error("unimplemented control bits nonzero");
   chk_wen_gate: assert property (@(posedge pclk)
      disable iff (!presetn)
      (!wen && !fwd_s) |=> !wake_msg_out)
      else $error("wake message without enable");

   // ---------------------------------------------------------------
   // Write, lock and read-back checks
   // ---------------------------------------------------------------
   // Lock and sticky paths are what a plain register test misses
   chk_wst_clear: assert property (@(posedge pclk)
      disable iff (!presetn || !sticky_rstn)
      (wr && hit_csr && pstrb[1] && pwdata[SPPM_WST_BIT] && !own_evt)
      |=> !wst)
      else $error("wake status not cleared by write of one");
   chk_wen_write: assert property (@(posedge pclk)
      disable iff (!presetn || !sticky_rstn)
      (wr && hit_csr && pstrb[1]) |=> wen == $past(pwdata[SPPM_WEN_BIT]))
      else $error("wake enable did not take written value");
   chk_cap_lock: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_cap && !cfg_unlock)
      |=> $stable(devinit) && $stable(wmask_adv))
      else $error("locked capability field changed");
   chk_keep_lock: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_csr && !cfg_unlock) |=> $stable(keep))
      else $error("locked context flag changed");
   chk_hot_state: assert property (@(posedge pclk)
      disable iff (!presetn)
      hot_reset |=> power_state_field == SPPM_D0)
      else $error("hot reset left power state");
   chk_d3_write: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_csr && pstrb[0] && !hot_reset &&
       next_power_state_field == SPPM_D3HOT) |=> power_state_field == SPPM_D3HOT)
      else $error("write of D3hot not taken");
   chk_mask_fixed: assert property (@(posedge pclk)
      disable iff (!presetn)
      (fwd_s && !cold_s) |=> wake_msg_out)
      else $error("forwarded wake dropped in allowed state");
   chk_status_up: assert property (@(posedge pclk)
      disable iff (!presetn || !sticky_rstn)
      IS_UPSTREAM |-> !wst)
      else $error("upstream port wake status set");
   chk_cold_status: assert property (@(posedge pclk)
      disable iff (!presetn || !sticky_rstn)
      (cold_s && !wst) |=> !wst)
      else $error("wake status set in cold D3");
   chk_pschg_flag: assert property (@(posedge pclk)
      disable iff (!presetn)
      ev[SPPM_IRQ_PSCHG] |=> ist[SPPM_IRQ_PSCHG])
      else $error("power change flag not set");
   chk_read_csr: assert property (@(posedge pclk)
      disable iff (!presetn)
      (psel && !penable && !pwrite && hit_csr) |=> prdata == $past(csr_word))
      else $error("control word read back wrong");
   chk_read_cap: assert property (@(posedge pclk)
      disable iff (!presetn)
      (psel && !penable && !pwrite && hit_cap) |=> prdata == $past(cap_word))
      else $error("capability word read back wrong");
endmodule
`default_nettype wire

// file: verif/sppm_root_model.sv
// Upstream root model that counts cycles of wake requests
`timescale 1ns/1ps
`default_nettype none
module sppm_root_model (
   // Clock
   input  wire logic pclk,
   // Wake request and counter clear
   input  wire logic wake_msg_out,
   input  wire logic clr,
   output var int    msg_cycles
);
   // ---------------------------------------------------------------
   // Wake capture
   // ---------------------------------------------------------------
   // Counts cycles, not edges, so a stuck request also shows up
   always_ff @(posedge pclk) begin
      if (clr)
         msg_cycles <= 0;
      else if (wake_msg_out === 1'b1)
         msg_cycles <= msg_cycles + 1;
   end
endmodule
`default_nettype wire

// file: verif/switch_port_power_mgmt_regs_bench.sv
// Self-checking bench of the port power register bank
`timescale 1ns/1ps
`default_nettype none
module switch_port_power_mgmt_regs_bench;
   import sppm_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        pclk        = 1'b0;
   logic        presetn     = 1'b0;
   logic        sticky_rstn = 1'b0;
   logic        hot_reset   = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [7:0]  paddr       = 8'h00;
   logic [31:0] pwdata      = 32'h0;
   logic [3:0]  pstrb       = 4'hF;
   logic        cfg_unlock  = 1'b0;
   logic        cold_d3     = 1'b0;
   logic        own_wake    = 1'b0;
   logic        fwd_wake    = 1'b0;
   logic        clr         = 1'b0;
   logic [31:0] prdata;
   logic [31:0] prdata_up;
   logic        pready;
   logic        pslverr;
   logic        wake_msg_out;
   logic [1:0]  power_state;
   logic        context_keep;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   int          msg_cycles;
   int          failures    = 0;
   int          check_count = 0;
   localparam logic [31:0] CAP_RST = {SPPM_WMASK_RST, 8'h00, SPPM_VER,
                                      SPPM_NEXT_DOWN, SPPM_CAP_ID};
   localparam logic [31:0] CAP_UP  = {SPPM_WMASK_RST, 8'h00, SPPM_VER,
                                      SPPM_NEXT_UP, SPPM_CAP_ID};
   localparam logic [31:0] LOCKED  = 32'hF820_0000;

   always #50 pclk = ~pclk;

   sppm_regs dut (.pclk(pclk), .presetn(presetn), .sticky_rstn(sticky_rstn),
      .hot_reset(hot_reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_unlock(cfg_unlock), .cold_d3(cold_d3), .own_wake(own_wake),
      .fwd_wake(fwd_wake), .wake_msg_out(wake_msg_out),
      .power_state(power_state), .context_keep(context_keep), .irq(irq));

   sppm_root_model root (.pclk(pclk), .wake_msg_out(wake_msg_out),
      .clr(clr), .msg_cycles(msg_cycles));

   // Second port in the upstream role, same bus and pins
   sppm_regs #(.IS_UPSTREAM(1'b1)) dut_up (.pclk(pclk), .presetn(presetn),
      .sticky_rstn(sticky_rstn), .hot_reset(hot_reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata_up), .pready(), .pslverr(),
      .cfg_unlock(cfg_unlock), .cold_d3(cold_d3), .own_wake(own_wake),
      .fwd_wake(fwd_wake), .wake_msg_out(), .power_state(),
      .context_keep(), .irq());

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Pin pulse of one cycle, then time for synchronisers to settle
   task automatic pulse(input logic own);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      own_wake <= own;
      fwd_wake <= ~own;
      @(posedge pclk);
      own_wake <= 1'b0;
      fwd_wake <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask

   task automatic csr_is(input logic [31:0] exp);
      apb(1'b0, SPPM_CSR_ADDR, 32'h0);
      chk("control word", exp, rd);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      apb(1'b0, SPPM_CAP_ADDR, 32'h0);
      chk("capability", CAP_RST, rd);
      chk("up capability", CAP_UP, prdata_up);
      csr_is(32'h0000_0008);
      chk("keep pin", 32'h1, {31'h0, context_keep});
      chk("wake out", 32'h0, {31'h0, wake_msg_out});
      $display("test reset done");
   endtask

   task automatic t_lock;
      apb(1'b1, SPPM_CAP_ADDR, 32'hFFFF_FFFF);
      apb(1'b1, SPPM_CSR_ADDR, 32'h0);
      apb(1'b0, SPPM_CAP_ADDR, 32'h0);
      chk("locked cap", CAP_RST, rd);
      csr_is(32'h0000_0008);
      cfg_unlock <= 1'b1;
      apb(1'b1, SPPM_CAP_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, SPPM_CAP_ADDR, 32'h0);
      chk("open cap", CAP_RST | LOCKED, rd);
      apb(1'b1, SPPM_CAP_ADDR, 32'h0);
      apb(1'b0, SPPM_CAP_ADDR, 32'h0);
      chk("cleared cap", CAP_RST & ~LOCKED, rd);
      apb(1'b1, SPPM_CSR_ADDR, 32'h0);
      csr_is(32'h0);
      chk("keep pin", 32'h0, {31'h0, context_keep});
      apb(1'b1, SPPM_CSR_ADDR, 32'h8);
      cfg_unlock <= 1'b0;
      $display("test lock done");
   endtask

   task automatic t_power_state_field;
      logic [1:0] w [4];
      logic [1:0] e [4];
      w = '{2'h3, 2'h1, 2'h2, 2'h0};
      e = '{2'h3, 2'h3, 2'h3, 2'h0};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, SPPM_CSR_ADDR, {30'h2, w[i]});
         csr_is({30'h2, e[i]});
         chk("state pin", {30'h0, e[i]}, {30'h0, power_state});
      end
      apb(1'b0, SPPM_IRQ_ST_ADDR, 32'h0);
      chk("change flag", 32'h2, rd & 32'h2);
      $display("test power state done");
   endtask

   task automatic t_wake;
      apb(1'b1, SPPM_IRQ_ST_ADDR, 32'h3);
      apb(1'b1, SPPM_IRQ_MK_ADDR, 32'h1);
      pulse(1'b1);
      chk("msg off", 32'h0, {31'h0, msg_cycles != 0});
      csr_is(32'h0000_8008);
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, SPPM_IRQ_MK_ADDR, 32'h0);
      // Mask lands on the edge the write ends on; look one edge later
      @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, SPPM_IRQ_ST_ADDR, 32'h1);
      apb(1'b1, SPPM_CSR_ADDR, 32'h0000_8008);
      csr_is(32'h0000_0008);
      apb(1'b1, SPPM_CSR_ADDR, 32'h0000_0108);
      pulse(1'b1);
      chk("msg own", 32'h1, {31'h0, msg_cycles != 0});
      csr_is(32'h0000_8108);
      chk("up status", 32'h0000_0108, prdata_up);
      apb(1'b1, SPPM_CSR_ADDR, 32'h0000_810B);
      pulse(1'b0);
      chk("msg fwd", 32'h1, {31'h0, msg_cycles != 0});
      csr_is(32'h0000_010B);
      pulse(1'b1);
      chk("msg d3hot", 32'h1, {31'h0, msg_cycles != 0});
      apb(1'b1, SPPM_CSR_ADDR, 32'h0000_8108);
      cold_d3 <= 1'b1;
      pulse(1'b1);
      chk("cold own", 32'h0, {31'h0, msg_cycles != 0});
      pulse(1'b0);
      chk("cold fwd", 32'h0, {31'h0, msg_cycles != 0});
      cold_d3 <= 1'b0;
      $display("test wake done");
   endtask

   task automatic t_resets;
      apb(1'b1, SPPM_CSR_ADDR, 32'h0000_010B);
      hot_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      hot_reset <= 1'b0;
      csr_is(32'h0000_0108);
      chk("state pin", 32'h0, {30'h0, power_state});
      sticky_rstn <= 1'b0;
      @(posedge pclk);
      sticky_rstn <= 1'b1;
      csr_is(32'h0000_0008);
      apb(1'b1, 8'h10, 32'hFFFF_FFFF);
      chk("write error", 32'h1, {31'h0, err});
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped read", 32'h0, rd);
      $display("test resets done");
   endtask

   // ---------------------------------------------------------------
   // Run and verdict
   // ---------------------------------------------------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge pclk);
      presetn     <= 1'b1;
      sticky_rstn <= 1'b1;
      t_reset();
      t_lock();
      t_power_state_field();
      t_wake();
      t_resets();
      print_verdict();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      failures++;
      print_verdict();
   end
endmodule
`default_nettype wire
